/* File: logic/dram_refresh_pkg.sv */
package dram_refresh_pkg;

	// Clock and refresh timing
	localparam int CLOCK_PERIOD_NS   = 50;
	localparam int TICK_PERIOD_NS    = 30000;
	localparam int MAX_SPACING_NS    = 31200;
	localparam int INTERVAL_NS       = 2000000;
	localparam int TICK_CYCLES       = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
	localparam int MAX_SPACING_CYCLES = MAX_SPACING_NS / CLOCK_PERIOD_NS;
	localparam int INTERVAL_CYCLES   = INTERVAL_NS / CLOCK_PERIOD_NS;

	// Array geometry
	localparam int ROWS_4K           = 64;
	localparam int ROWS_16K          = 128;
	localparam int ROW_BITS          = 7;
	localparam int ADDR_BITS         = 15;
	localparam int REFRESH_CLOCKS    = 2;
	localparam int MAX_MEM_CYCLES    = 3;
	localparam int CLOCKS_PER_ROW_BLK = 2;

	// Refresh modes
	typedef enum logic [1:0] {
		MODE_CYCLE_STEAL,
		MODE_BLOCK,
		MODE_TRANSPARENT
	} refresh_mode_t;

	// Processor memory bus as seen by the controller
	typedef struct packed {
		logic                 memory_cycle_enable_n;
		logic                 bus_read_direction;
		logic                 bus_hold_acknowledge;
		logic [ADDR_BITS-1:0] address;
	} cpu_bus_t;

	// Drive toward the dynamic RAM array
	typedef struct packed {
		logic                 chip_enable;
		logic                 write_enable;
		logic [ADDR_BITS-1:0] address;
	} dram_drive_t;

endpackage

/* File: logic/refresh_timer.sv */
`timescale 1ns/1ns
`default_nettype none

// Free-running divider that emits a one-cycle pulse every PERIOD clocks
module refresh_timer #(
	parameter int PERIOD = 600
) (
	input  wire logic clock,
	input  wire logic rst_n,
	output logic      tick
);
	localparam int W = $clog2(PERIOD + 1);

	logic [W-1:0] count_q;
	logic [W-1:0] count_d;
	logic         wrap;

	assign wrap    = (count_q == W'(PERIOD - 1));
	assign count_d = wrap ? '0 : count_q + W'(1);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
			tick    <= 1'b0;
		end else begin
			count_q <= count_d;
			tick    <= wrap;
		end
	end
endmodule // refresh_timer

`default_nettype wire

/* File: logic/row_counter.sv */
`timescale 1ns/1ns
`default_nettype none

// Refresh row address counter with overflow flag on the last row
module row_counter #(
	parameter int BITS = 7
) (
	input  wire logic            clock,
	input  wire logic            rst_n,
	input  wire logic            advance,
	input  wire logic [BITS-1:0] last_row,
	output logic      [BITS-1:0] row,
	output logic                 at_last
);
	logic [BITS-1:0] row_d;

	assign at_last = (row == last_row);
	assign row_d   = at_last ? '0 : row + BITS'(1);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			row <= '0;
		else if (advance)
			row <= row_d;
	end
endmodule // row_counter

`default_nettype wire

/* File: logic/dram_refresh_controller.sv */
`timescale 1ns/1ns
`default_nettype none

module dram_refresh_controller #(
	parameter int                            TICK_CYCLES     = dram_refresh_pkg::TICK_CYCLES,
	parameter int                            INTERVAL_CYCLES = dram_refresh_pkg::INTERVAL_CYCLES
) (
	input  wire logic                        clock,
	input  wire logic                        reset_n,
	input  wire dram_refresh_pkg::refresh_mode_t mode,
	input  wire logic                        large_array,
	input  wire dram_refresh_pkg::cpu_bus_t  cpu_bus,
	input  wire logic                        dma_hold_request,
	output dram_refresh_pkg::dram_drive_t    dram,
	output logic                             memory_ready,
	output logic                             cpu_halt,
	output logic                             hold_request_gated,
	output logic                             hold_acknowledge_gated,
	output logic                             refresh_request,
	output logic                             refresh_grant
);
	localparam int RB = dram_refresh_pkg::ROW_BITS;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FIRST,
		ST_LAST
	} ref_state_t;

	logic                rst_sync_q;
	logic                rst_n_q;
	ref_state_t          state_q;
	ref_state_t          state_d;
	logic                req_q;
	logic                block_q;
	logic                done_q;
	logic                memory_cycle_enable_n_n_q;
	logic [RB-1:0]       row;
	logic [RB-1:0]       last_row;
	logic                at_last;
	logic                tick;
	logic                interval_tick;
	logic                cpu_mem;
	logic                memory_cycle_enable_n_rise;
	logic                start_ok;
	logic                start;
	logic                finish;
	logic                set_req;
	logic                wait_now;
	dram_refresh_pkg::dram_drive_t dram_d;

	// Reset release through two flops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_sync_q <= 1'b1;
			rst_n_q    <= rst_sync_q;
		end
	end

	refresh_timer #(.PERIOD(TICK_CYCLES)) u_tick (
		.clock (clock),
		.rst_n (rst_n_q),
		.tick  (tick)
	);

	refresh_timer #(.PERIOD(INTERVAL_CYCLES)) u_interval (
		.clock (clock),
		.rst_n (rst_n_q),
		.tick  (interval_tick)
	);

	assign last_row = large_array ? RB'(dram_refresh_pkg::ROWS_16K - 1)
	                              : RB'(dram_refresh_pkg::ROWS_4K - 1);

	row_counter #(.BITS(RB)) u_rows (
		.clock    (clock),
		.rst_n    (rst_n_q),
		.advance  (finish),
		.last_row (last_row),
		.row      (row),
		.at_last  (at_last)
	);

	// Memory enable low with the bus in processor hands marks a memory cycle
	assign cpu_mem    = !cpu_bus.memory_cycle_enable_n && !cpu_bus.bus_hold_acknowledge;
	assign memory_cycle_enable_n_rise = cpu_bus.memory_cycle_enable_n && !memory_cycle_enable_n_n_q;

	// When a refresh may begin, per mode
	assign start_ok = (mode == dram_refresh_pkg::MODE_BLOCK)       ? block_q :
	                  (mode == dram_refresh_pkg::MODE_TRANSPARENT) ? memory_cycle_enable_n_rise && !done_q
	                                                               : !cpu_mem;
	assign start   = (state_q == ST_IDLE) && req_q && start_ok && !cpu_bus.bus_hold_acknowledge;
	assign finish  = (state_q == ST_LAST);
	assign set_req = (mode == dram_refresh_pkg::MODE_TRANSPARENT) ? !done_q
	               : (mode == dram_refresh_pkg::MODE_BLOCK) ? block_q
	               : tick;
	assign wait_now = (state_q == ST_LAST) && cpu_mem;

	always_comb begin
		case (state_q)
			ST_IDLE: state_d = start ? ST_FIRST : ST_IDLE;
			ST_FIRST: state_d = ST_LAST;
			ST_LAST: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// Shared chip-enable timing and row/processor address mux
	assign dram_d.chip_enable  = (state_q != ST_IDLE) || start || cpu_mem;
	assign dram_d.write_enable = (state_q == ST_IDLE) && !start && cpu_mem
	                             && !cpu_bus.bus_read_direction;
	assign dram_d.address      = (start || state_q != ST_IDLE)
	                             ? {{(dram_refresh_pkg::ADDR_BITS - RB){1'b0}}, row}
	                             : cpu_bus.address;

	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q   <= ST_IDLE;
			req_q     <= 1'b0;
			block_q   <= 1'b0;
			done_q    <= 1'b0;
			memory_cycle_enable_n_n_q <= 1'b1;
		end else begin
			state_q   <= state_d;
			memory_cycle_enable_n_n_q <= cpu_bus.memory_cycle_enable_n;
			// Set wins over the clear when both land together
			req_q     <= set_req || (req_q && !finish);
			if (interval_tick)
				block_q <= (mode == dram_refresh_pkg::MODE_BLOCK);
			else if (finish && at_last)
				block_q <= 1'b0;
			if (interval_tick)
				done_q <= 1'b0;
			else if (finish && at_last && mode == dram_refresh_pkg::MODE_TRANSPARENT)
				done_q <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dram                   <= '0;
			memory_ready           <= 1'b1;
			cpu_halt               <= 1'b0;
			hold_request_gated     <= 1'b0;
			hold_acknowledge_gated <= 1'b0;
			refresh_request        <= 1'b0;
			refresh_grant          <= 1'b0;
		end else begin
			dram                   <= dram_d;
			memory_ready           <= !wait_now;
			cpu_halt               <= block_q;
			hold_request_gated     <= dma_hold_request && !req_q;
			hold_acknowledge_gated <= cpu_bus.bus_hold_acknowledge && !req_q;
			refresh_request        <= req_q;
			refresh_grant          <= start || state_q == ST_FIRST;
		end
	end
endmodule // dram_refresh_controller

`default_nettype wire

/* File: verification/dram_refresh_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module dram_refresh_checker (
	input wire logic                            clock,
	input wire logic                            reset_n,
	input wire dram_refresh_pkg::refresh_mode_t mode,
	input wire logic                            large_array,
	input wire dram_refresh_pkg::dram_drive_t   dram,
	input wire logic                            memory_ready,
	input wire logic                            cpu_halt,
	input wire logic                            hold_request_gated,
	input wire logic                            hold_acknowledge_gated,
	input wire logic                            refresh_request,
	input wire logic                            refresh_grant
);
	logic [6:0] last_q;
	logic       seen_q;
	wire  [6:0] mask = large_array ? 7'h7F : 7'h3F;
	// Remembers the row of the previous refresh
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			last_q <= 7'h00;
			seen_q <= 1'b0;
		end else if ($rose(refresh_grant)) begin
			last_q <= dram.address[6:0];
			seen_q <= 1'b1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	AST_GRANT_TWO: assert property ($rose(refresh_grant) |=> refresh_grant ##1 !refresh_grant)
		else $error("grant length wrong");
	AST_REQ_HELD: assert property ($fell(refresh_request) |-> $past(refresh_grant, 2))
		else $error("request dropped early");
	AST_ROW_MUX: assert property (refresh_grant |-> dram.chip_enable && !dram.address[14:7])
		else $error("refresh address or enable wrong");
	AST_ROW_STEP: assert property ($rose(refresh_grant) && seen_q |->
		dram.address[6:0] == ((last_q + 7'h01) & mask))
		else $error("row sequence wrong");
	AST_HOLD_GATE: assert property (refresh_request |-> !hold_request_gated)
		else $error("hold request not gated");
	AST_BUS_HOLD_ACKNOWLEDGE_GATE: assert property (refresh_request |-> !hold_acknowledge_gated)
		else $error("hold ack not gated");
	AST_READY_CAUSE: assert property (!memory_ready |-> refresh_grant || $past(refresh_grant))
		else $error("wait outside refresh");
	AST_GRANT_BOUND: assert property ($rose(refresh_request) &&
		mode == dram_refresh_pkg::MODE_CYCLE_STEAL |-> ##[0:30] refresh_grant)
		else $error("grant too late");
	AST_HALT_MODE: assert property (cpu_halt |-> mode == dram_refresh_pkg::MODE_BLOCK)
		else $error("halt outside block mode");
	C_GRANT: cover property ($rose(refresh_grant));
	C_WAIT: cover property (!memory_ready);
	C_HALT: cover property ($rose(cpu_halt));
endmodule // dram_refresh_checker
`default_nettype wire

/* File: verification/cpu_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model (
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic                  memory_ready,
	input  wire logic                  hold_request_gated,
	output dram_refresh_pkg::cpu_bus_t cpu_bus
);
	int run;
	initial begin
		cpu_bus = {1'b1, 1'b1, 1'b0, 15'h0000};
		run = 0;
	end
	always @(negedge clock) begin
		cpu_bus.bus_hold_acknowledge <= hold_request_gated && reset_n;
		if (!reset_n || cpu_bus.memory_cycle_enable_n || memory_ready) begin
			// Wait states hold every bus signal except bus_hold_acknowledge, which still follows hold_request_gated
			if (reset_n && run < 3 && $urandom_range(1, 0)) begin
				cpu_bus.memory_cycle_enable_n <= 1'b0;
				cpu_bus.bus_read_direction <= 1'($urandom);
				cpu_bus.address <= 15'($urandom);
				run <= run + 1;
			end else begin
				// Released bus shows no stale address; random rows alone never cover the array
				cpu_bus.memory_cycle_enable_n <= 1'b1;
				cpu_bus.address <= ~cpu_bus.address;
				run <= 0;
			end
		end
	end
endmodule // cpu_bus_model
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int TICK = 20;
	localparam int IVL = 400;
	localparam int RUN = 3000;
	logic                            clock = 1'b0;
	logic                            reset_n = 1'b0;
	dram_refresh_pkg::refresh_mode_t mode = dram_refresh_pkg::MODE_CYCLE_STEAL;
	logic                            large_array = 1'b0;
	logic                            dma_hold_request = 1'b0;
	dram_refresh_pkg::cpu_bus_t      cpu_bus;
	dram_refresh_pkg::dram_drive_t   dram;
	logic                            memory_ready, cpu_halt, refresh_request, refresh_grant;
	logic                            hold_request_gated, hold_acknowledge_gated, grant_q;
	logic [127:0]                    seen;
	int                              grants, waits, halts, fail_count, n_compared;
	always #25 clock = ~clock;
	dram_refresh_controller #(.TICK_CYCLES(TICK), .INTERVAL_CYCLES(IVL)) dut_u (
		.clock(clock), .reset_n(reset_n), .mode(mode), .large_array(large_array),
		.cpu_bus(cpu_bus), .dma_hold_request(dma_hold_request), .dram(dram),
		.memory_ready(memory_ready), .cpu_halt(cpu_halt),
		.hold_request_gated(hold_request_gated), .hold_acknowledge_gated(hold_acknowledge_gated),
		.refresh_request(refresh_request), .refresh_grant(refresh_grant));
	cpu_bus_model bus_u (.clock(clock), .reset_n(reset_n), .memory_ready(memory_ready),
		.hold_request_gated(hold_request_gated), .cpu_bus(cpu_bus));
	always @(posedge clock) begin
		grant_q <= refresh_grant;
		if (refresh_grant === 1'b1 && grant_q !== 1'b1) begin
			grants <= grants + 1;
			seen[dram.address[6:0]] <= 1'b1;
		end
		if (memory_ready === 1'b0) waits <= waits + 1;
		if (cpu_halt === 1'b1) halts <= halts + 1;
	end
	task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
		n_compared++;
		if (seen_v !== exp_v) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
		end
	endtask
	function automatic int lo_of(input int m, input int r);
		return m == 0 ? RUN / TICK - 5 : (m == 1 ? 6 * r : 1);
	endfunction
	function automatic int hi_of(input int m, input int r);
		return m == 0 ? RUN / TICK + 1 : 8 * r;
	endfunction
	task automatic finish_test();
		$display("compared=%0d mismatches=%0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		void'($urandom(14));
		for (int m = 0; m < 3; m++) begin
			for (int la = 0; la < 2; la++) begin
				@(negedge clock);
				reset_n = 1'b0;
				mode = dram_refresh_pkg::refresh_mode_t'(m);
				large_array = la[0];
				repeat (10) @(negedge clock);
				reset_n = 1'b1;
				grants = 0;
				waits = 0;
				halts = 0;
				seen = '0;
				repeat (RUN) begin
					@(negedge clock);
					dma_hold_request = ($urandom_range(3, 0) == 0);
				end
				check(32'($countones(seen)), la[0] ? 32'd128 : 32'd64);
				check(32'(grants >= lo_of(m, la[0] ? 128 : 64)), 32'h1);
				check(32'(grants <= hi_of(m, la[0] ? 128 : 64)), 32'h1);
				check(32'(waits <= 2 * grants), 32'h1);
				check(32'(halts != 0), 32'(m == 1));
				$display("test mode=%0d large=%0d grants=%0d waits=%0d", m, la, grants, waits);
			end
		end
		finish_test();
	end
endmodule // tb_top
bind dram_refresh_controller dram_refresh_checker chk_u (.clock(clock), .reset_n(reset_n),
	.mode(mode), .large_array(large_array), .dram(dram), .memory_ready(memory_ready),
	.cpu_halt(cpu_halt), .hold_request_gated(hold_request_gated),
	.hold_acknowledge_gated(hold_acknowledge_gated), .refresh_request(refresh_request),
	.refresh_grant(refresh_grant));
`default_nettype wire
